// ==== logic/aop_ctrl_map.vh ====
// Register indexes, field positions, reset values and timing counts
`ifndef AOP_CTRL_MAP_VH
`define AOP_CTRL_MAP_VH

// Register indexes; byte address is four times the index
`define AOP_IDX_STATUS 8'h01
`define AOP_IDX_POWER 8'h08
`define AOP_IDX_STAB 8'h09
`define AOP_IDX_OUTPUT 8'h14
`define AOP_IDX_LINK 8'h16

// Power register fields
`define AOP_PWR_MODE_LO 0
`define AOP_PWR_MODE_HI 1
`define AOP_PWR_PINFN 2
`define AOP_PWR_NORMAL 2'h0
`define AOP_PWR_FULL 2'h1
`define AOP_PWR_STANDBY 2'h2
`define AOP_PWR_RESET 3'h0

// Stabilizer register: bit 0 enables, on by default
`define AOP_STAB_EN 0
`define AOP_STAB_RESET 8'h01

// Output register fields
`define AOP_OUT_FMT_LO 0
`define AOP_OUT_FMT_HI 1
`define AOP_OUT_DIS 4
`define AOP_FMT_OFFSET 2'h0
`define AOP_FMT_TWOS 2'h1
`define AOP_FMT_GRAY 2'h2
`define AOP_OUT_RESET 8'h00

// Link register fields
`define AOP_LNK_LVDS 0
`define AOP_LNK_RSWING 1
`define AOP_LNK_INVERT 2
`define AOP_LNK_RESET 3'h0

// Status register fields
`define AOP_ST_PINMODE 0
`define AOP_ST_FULLPD 1
`define AOP_ST_STANDBY 2
`define AOP_ST_LVDS 3
`define AOP_ST_RSWING 4
`define AOP_ST_THREE 5
`define AOP_ST_OVR 6
`define AOP_ST_STAB 7

// Pipeline latency in sample clock cycles
`define AOP_LATENCY 12
`define AOP_DATA_W 16

`endif

// ==== logic/aop_pipe.v ====
// Fixed-latency delay line for converted words
`timescale 1ns/1ps
module aop_pipe #(
  parameter WIDTH = 17,
  parameter DEPTH = 12
) (
  input wire pclk, // System clock
  input wire presetn, // Asynchronous reset, active low
  input wire advance, // Shift one stage
  input wire [WIDTH-1:0] din, // Word entering the pipe
  output wire [WIDTH-1:0] dout // Word DEPTH advances old
);

  reg [WIDTH-1:0] stage_r [0:DEPTH-1];
  integer i;

  // ==========================================================
  // Shift chain
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        stage_r[i] <= {WIDTH{1'b0}};
    end
    else if (advance)
    begin
      stage_r[0] <= din;
      for (i = 1; i < DEPTH; i = i + 1)
        stage_r[i] <= stage_r[i-1];
    end
  end

  assign dout = stage_r[DEPTH-1];

endmodule

// ==== logic/aop_ctrl.v ====
// Output port, power and coding control of a 16-bit converter back end
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "aop_ctrl_map.vh"
module aop_ctrl #(
  parameter DW = `AOP_DATA_W,
  parameter LATENCY = `AOP_LATENCY
) (
  input wire pclk, // 50 MHz system clock
  input wire presetn, // Asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error for unmapped address
  input wire sample_clk, // Sample clock pin
  input wire [DW-1:0] conv_word, // Core result, offset binary
  input wire conv_over_hi, // Core input above full scale
  input wire conv_over_lo, // Core input below full scale
  input wire power_down_pin, // Power-down pin
  input wire output_three_state_ctl, // Three-state pin, high disables
  input wire lvds_select_pin, // LVDS select pin
  input wire reduced_swing_select, // Reduced swing pin
  input wire format_select_pin, // Format pin in pin mode
  input wire stabilizer_select_pin, // Stabilizer pin in pin mode
  input wire serial_select_n, // Serial chip select, active low
  output reg [DW-1:0] data_out, // Output data bits
  output reg data_oe, // Data drivers enabled
  output reg over_range_out, // Over-range flag
  output reg data_capture_clock_out, // CMOS capture clock
  output reg dco_p, // LVDS capture clock, true
  output reg dco_n, // LVDS capture clock, complement
  output reg dco_oe, // Capture clock drivers enabled
  output reg lvds_mode, // LVDS drivers selected
  output reg reduced_swing, // Reduced swing drive selected
  output reg duty_cycle_stabilizer, // Stabilizer enable
  output reg clock_run, // Internal clock running
  output reg reference_on, // Reference and buffer powered
  output reg bias_on // Bias networks powered
);

  // ==========================================================
  // Functions
  function [DW-1:0] code_word;
    input [DW-1:0] ob;
    input [1:0] fmt;
    begin
      case (fmt)
        `AOP_FMT_TWOS: code_word = {~ob[DW-1], ob[DW-2:0]};
        `AOP_FMT_GRAY: code_word = ob ^ {1'b0, ob[DW-1:1]};
        default: code_word = ob;
      endcase
    end
  endfunction

  function [7:0] reg_index;
    input [11:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  // ==========================================================
  // Input synchronisers
  localparam NPIN = 7;
  // Select idles high; a low reset value would lock serial mode at once
  localparam [NPIN-1:0] PIN_IDLE = 7'h20;
  wire [NPIN-1:0] pin_raw;
  reg [NPIN-1:0] pin_s1_r;
  reg [NPIN-1:0] pin_s2_r;
  reg [DW+2:0] cw_s1_r;
  reg [DW+2:0] cw_s2_r;
  reg clk_prev_r;

  assign pin_raw = {sample_clk, serial_select_n, stabilizer_select_pin,
                    format_select_pin, reduced_swing_select,
                    lvds_select_pin, power_down_pin};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
      cw_s1_r <= {(DW+3){1'b0}};
      cw_s2_r <= {(DW+3){1'b0}};
      clk_prev_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      cw_s1_r <= {conv_over_hi, conv_over_lo, 1'b0, conv_word};
      cw_s2_r <= cw_s1_r;
      clk_prev_r <= pin_s2_r[6];
    end
  end

  wire pd_pin = pin_s2_r[0];
  wire lvds_pin = pin_s2_r[1];
  wire rs_pin = pin_s2_r[2];
  wire fmt_pin = pin_s2_r[3];
  wire stab_pin = pin_s2_r[4];
  wire csn_s = pin_s2_r[5];
  wire sclk_s = pin_s2_r[6];
  wire sclk_rise = sclk_s & ~clk_prev_r;
  wire sclk_fall = ~sclk_s & clk_prev_r;

  // ==========================================================
  // Pin mode versus serial mode
  reg pin_mode_r;
  reg mode_seen_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_mode_r <= 1'b1;
      mode_seen_r <= 1'b0;
    end
    else
    begin
      mode_seen_r <= 1'b1;
      // Select seen low once locks serial mode for good
      if (mode_seen_r && !csn_s)
        pin_mode_r <= 1'b0;
    end
  end

  // ==========================================================
  // APB register file
  reg [2:0] pwr_r;
  reg [7:0] stab_r;
  reg [7:0] out_r;
  reg [2:0] link_r;
  reg [7:0] status_r;
  wire [7:0] idx = reg_index(paddr);
  wire access = psel & penable;
  wire wr_en = access & pready & pwrite;
  reg mapped;

  always @*
  begin
    case (idx)
      `AOP_IDX_STATUS, `AOP_IDX_POWER, `AOP_IDX_STAB,
      `AOP_IDX_OUTPUT, `AOP_IDX_LINK: mapped = (paddr[11:10] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwr_r <= `AOP_PWR_RESET;
      stab_r <= `AOP_STAB_RESET;
      out_r <= `AOP_OUT_RESET;
      link_r <= `AOP_LNK_RESET;
    end
    else if (wr_en && mapped)
    begin
      case (idx)
        `AOP_IDX_POWER: pwr_r <= pwdata[2:0];
        `AOP_IDX_STAB: stab_r <= pwdata[7:0];
        `AOP_IDX_OUTPUT: out_r <= pwdata[7:0];
        `AOP_IDX_LINK: link_r <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // One wait state: ready rises in the second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata <= 32'h0;
      if (access && !pready && !pwrite)
      begin
        case (idx)
          `AOP_IDX_STATUS: prdata <= {24'h0, status_r};
          `AOP_IDX_POWER: prdata <= {29'h0, pwr_r};
          `AOP_IDX_STAB: prdata <= {24'h0, stab_r};
          `AOP_IDX_OUTPUT: prdata <= {24'h0, out_r};
          `AOP_IDX_LINK: prdata <= {29'h0, link_r};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // Effective controls
  wire ser = ~pin_mode_r;
  wire [1:0] pmode = pwr_r[`AOP_PWR_MODE_HI:`AOP_PWR_MODE_LO];
  wire pin_to_sb = ser & pwr_r[`AOP_PWR_PINFN];
  // Pin low with no register request returns to normal
  wire full_pd = (pd_pin & ~pin_to_sb) |
                 (ser & (pmode == `AOP_PWR_FULL));
  wire standby = ~full_pd & ((pd_pin & pin_to_sb) |
                 (ser & (pmode == `AOP_PWR_STANDBY)));
  wire lvds_eff = lvds_pin | (ser & link_r[`AOP_LNK_LVDS]);
  wire rs_eff = lvds_eff & (rs_pin |
                (ser & link_r[`AOP_LNK_RSWING]));
  wire inv_eff = ser & link_r[`AOP_LNK_INVERT] & ~lvds_eff;
  wire output_three_state_sync;
  wire three = output_three_state_sync | full_pd | standby |
               (ser & out_r[`AOP_OUT_DIS]);
  wire [1:0] fmt_eff = ser ? out_r[`AOP_OUT_FMT_HI:`AOP_OUT_FMT_LO] :
                       (fmt_pin ? `AOP_FMT_TWOS :
                        `AOP_FMT_OFFSET);
  wire stab_eff = ser ? stab_r[`AOP_STAB_EN] : stab_pin;
  wire running = ~full_pd & ~standby;

  // Three-state pin gets its own synchroniser pair
  reg oeb_s1_r;
  reg oeb_s2_r;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oeb_s1_r <= 1'b1;
      oeb_s2_r <= 1'b1;
    end
    else
    begin
      oeb_s1_r <= output_three_state_ctl;
      oeb_s2_r <= oeb_s1_r;
    end
  end
  assign output_three_state_sync = oeb_s2_r;

  // ==========================================================
  // Coding and saturation
  wire over_any = cw_s2_r[DW+2] | cw_s2_r[DW+1];
  wire [DW-1:0] sat_ob = cw_s2_r[DW+2] ? {DW{1'b1}} :
                         cw_s2_r[DW+1] ? {DW{1'b0}} :
                         cw_s2_r[DW-1:0];
  wire [DW:0] coded = {over_any, code_word(sat_ob, fmt_eff)};
  wire [DW:0] delayed;

  // Stopped internal clock freezes the pipe
  aop_pipe #(
    .WIDTH(DW+1),
    .DEPTH(LATENCY)
  ) u_pipe (
    .pclk(pclk),
    .presetn(presetn),
    .advance(sclk_rise & running),
    .din(coded),
    .dout(delayed)
  );

  // ==========================================================
  // Output port
  reg [DW-1:0] hold_r;
  integer b;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_out <= {DW{1'b0}};
      hold_r <= {DW{1'b0}};
      over_range_out <= 1'b0;
      data_oe <= 1'b0;
      dco_oe <= 1'b0;
      data_capture_clock_out <= 1'b0;
      dco_p <= 1'b0;
      dco_n <= 1'b1;
    end
    else
    begin
      data_oe <= ~three;
      dco_oe <= ~three;
      if (running)
      begin
        // CMOS clock falls as data moves, so its rise sits mid-eye
        data_capture_clock_out <= lvds_eff ? 1'b0 :
                                  (~sclk_s ^ inv_eff);
        dco_p <= lvds_eff & sclk_s;
        dco_n <= ~(lvds_eff & sclk_s);
      end
      if (running && sclk_rise)
      begin
        hold_r <= delayed[DW-1:0];
        over_range_out <= delayed[DW];
        if (lvds_eff)
        begin
          // Odd bits land on the rising edge
          for (b = 1; b < DW; b = b + 2)
            data_out[b] <= delayed[b];
        end
        else
          data_out <= delayed[DW-1:0];
      end
      if (running && sclk_fall && lvds_eff)
      begin
        // Even bits half a cycle later, hence 12.5
        for (b = 0; b < DW; b = b + 2)
          data_out[b] <= hold_r[b];
      end
    end
  end

  // ==========================================================
  // Mode and power outputs, status
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvds_mode <= 1'b0;
      reduced_swing <= 1'b0;
      duty_cycle_stabilizer <= 1'b1;
      clock_run <= 1'b1;
      reference_on <= 1'b1;
      bias_on <= 1'b1;
      status_r <= 8'h00;
    end
    else
    begin
      lvds_mode <= lvds_eff;
      reduced_swing <= rs_eff;
      duty_cycle_stabilizer <= stab_eff;
      clock_run <= running;
      reference_on <= ~full_pd;
      bias_on <= running;
      status_r <= {stab_eff, over_range_out, three, rs_eff, lvds_eff,
                   standby, full_pd, pin_mode_r};
    end
  end

endmodule

// ==== sim/aop_ctrl_assertions.sv ====
// Concurrent checks on the back-end control block ports
`timescale 1ns/1ps
// ==========
// Checker
module aop_ctrl_chk (
  input logic pclk, // Clock
  input logic presetn, // Reset
  input logic psel, // Select
  input logic penable, // Enable
  input logic pready, // Ready
  input logic power_down_pin, // Power-down pin
  input logic output_three_state_ctl, // Three-state pin
  input logic lvds_select_pin, // LVDS pin
  input logic reduced_swing_select, // Swing pin
  input logic stabilizer_select_pin, // Stabilizer pin
  input logic serial_select_n, // Chip select
  input logic data_oe, // Data enable
  input logic dco_oe, // Clock enable
  input logic lvds_mode, // LVDS on
  input logic reduced_swing, // Swing on
  input logic data_capture_clock_out, // CMOS clock
  input logic dco_p, // LVDS clock
  input logic dco_n, // LVDS clock bar
  input logic duty_cycle_stabilizer, // Stabilizer on
  input logic clock_run // Clock running
);
  logic pin_mode_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Raw select is seen before the design's synchronizer, so the
  // pin-mode checks stop slightly early rather than late
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pin_mode_r <= 1'b1;
    else if (!serial_select_n)
      pin_mode_r <= 1'b0;
  pd_tristate_a:
    assert property (power_down_pin [*5] |-> !data_oe && !dco_oe)
    else $error("outputs driven in power-down");
  pd_stop_a:
    assert property (power_down_pin [*5] |-> !clock_run)
    else $error("clock runs in power-down");
  oe_pin_a:
    assert property (output_three_state_ctl [*5] |-> !data_oe && !dco_oe)
    else $error("outputs driven while three-state pin high");
  lvds_pin_a:
    assert property (lvds_select_pin [*5] |-> lvds_mode)
    else $error("LVDS pin ignored");
  rswing_pin_a:
    assert property ((lvds_select_pin && reduced_swing_select) [*5]
      |-> reduced_swing)
    else $error("reduced swing pin ignored");
  dco_form_a:
    assert property ($stable(lvds_mode) [*3] |-> (lvds_mode ?
      !data_capture_clock_out : (!dco_p && dco_n)))
    else $error("capture clock form wrong for mode");
  stab_on_a:
    assert property ((pin_mode_r && stabilizer_select_pin) [*5]
      |-> duty_cycle_stabilizer)
    else $error("stabilizer off with pin high");
  stab_off_a:
    assert property (pin_mode_r && $fell(stabilizer_select_pin)
      |-> ##[1:6] !duty_cycle_stabilizer)
    else $error("stabilizer stays on with pin low");
  apb_wait_a:
    assert property (psel && $rose(penable) |=> pready)
    else $error("register answer not after one wait state");
  apb_pulse_a:
    assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  cover property (lvds_mode && data_oe);
  cover property (power_down_pin && !clock_run);
  cover property (psel && pready);
endmodule
bind aop_ctrl aop_ctrl_chk aop_ctrl_chk_inst (.*);

// ==== sim/aop_cap_model.sv ====
// Far-side capture register model
`timescale 1ns/1ps
// ==========
// Receiver
module aop_cap_model (
  input logic [15:0] data_out, // Data lines
  input logic over_range_out, // Over-range line
  input logic data_capture_clock_out, // CMOS clock
  input logic dco_p, // LVDS clock
  output logic [15:0] cmos_word, // Word at CMOS rise
  output logic cmos_ovr, // Flag at CMOS rise
  output logic [15:0] lvds_word // Word from both LVDS edges
);
  always @(posedge data_capture_clock_out)
  begin
    cmos_word <= data_out;
    cmos_ovr <= over_range_out;
  end
  // Each half moves at one edge, so it is taken at the other edge
  always @(posedge dco_p or negedge dco_p)
  begin
    if (dco_p)
    begin
      for (int i = 0; i < 16; i += 2)
        lvds_word[i] <= data_out[i];
    end
    else
    begin
      for (int i = 1; i < 16; i += 2)
        lvds_word[i] <= data_out[i];
    end
  end
endmodule

// ==== sim/aop_ctrl_tb.sv ====
// Self-checking bench for the back-end control block
`timescale 1ns/1ps
// ==========
// Bench top
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, sample_clk = 1'b0, co, sc_d = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] conv_word = 16'h8000, feed = 16'h8000, mword = 16'h2222;
  logic [15:0] data_out, cmos_word, lvds_word;
  logic conv_over_hi = 1'b0, conv_over_lo = 1'b0, hi = 1'b0, lo = 1'b0;
  logic power_down_pin = 1'b0, output_three_state_ctl = 1'b0;
  logic lvds_select_pin = 1'b0, reduced_swing_select = 1'b0;
  logic format_select_pin = 1'b0, stabilizer_select_pin = 1'b1;
  logic serial_select_n = 1'b1, cmos_ovr, data_oe, over_range_out;
  logic data_capture_clock_out, dco_p, dco_n, dco_oe, lvds_mode;
  logic reduced_swing, duty_cycle_stabilizer, clock_run;
  logic reference_on, bias_on;
  int fail_count = 0, checked = 0, cyc = 0, rises = 0, mark = -9, k;
  aop_ctrl aop_ctrl_inst (.*);
  aop_cap_model aop_cap_model_inst (.*);
  always #10 pclk = ~pclk;
  always #80 sample_clk = ~sample_clk;
  always @(posedge sample_clk) rises++;
  // New words go in just after a sample fall, well clear of the rise
  always @(posedge pclk)
  begin
    sc_d <= sample_clk;
    cyc <= cyc + 1;
    if (sc_d && !sample_clk)
    begin
      conv_word <= (rises == mark) ? mword : feed;
      conv_over_hi <= hi;
      conv_over_lo <= lo;
    end
    if (cyc == 30000)
    begin
      fail_count++;
      test_done;
    end
  end
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    co = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask
  task automatic waitr(input int n);
    k = rises + n;
    while (rises < k) @(posedge pclk);
  endtask
  task automatic dchk(input logic [15:0] w, input logic h, input logic l,
    input logic [15:0] exp, input logic ov);
    feed = w;
    hi = h;
    lo = l;
    waitr(15);
    chk(data_out, exp);
    chk(over_range_out, ov);
    chk(cmos_word, exp);
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========
  // Sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    chk({lvds_mode, duty_cycle_stabilizer}, 2'h1);
    apb(0, 12'h004, 0);
    chk(rd, 32'h81);
    stabilizer_select_pin <= 1'b0;
    settle;
    chk(duty_cycle_stabilizer, 0);
    stabilizer_select_pin <= 1'b1;
    dchk(16'h8000, 0, 0, 16'h8000, 0);
    format_select_pin <= 1'b1;
    dchk(16'h8000, 0, 0, 16'h0000, 0);
    dchk(16'h1234, 1, 0, 16'h7fff, 1);
    format_select_pin <= 1'b0;
    dchk(16'h1234, 1, 0, 16'hffff, 1);
    dchk(16'h1234, 0, 1, 16'h0000, 1);
    feed = 16'h1111;
    lo = 1'b0;
    mark = rises + 1;
    repeat (200) if (data_out !== mword) @(posedge pclk);
    chk(rises, mark + 13);
    output_three_state_ctl <= 1'b1;
    settle;
    chk({data_oe, dco_oe}, 2'h0);
    output_three_state_ctl <= 1'b0;
    settle;
    chk({data_oe, dco_oe}, 2'h3);
    power_down_pin <= 1'b1;
    settle;
    chk({data_oe, clock_run, reference_on, bias_on}, 4'h0);
    power_down_pin <= 1'b0;
    settle;
    chk({data_oe, clock_run, reference_on, bias_on}, 4'hf);
    lvds_select_pin <= 1'b1;
    reduced_swing_select <= 1'b1;
    feed = 16'ha5c3;
    waitr(15);
    chk({lvds_mode, reduced_swing, data_capture_clock_out}, 3'h6);
    chk(lvds_word, 16'ha5c3);
    lvds_select_pin <= 1'b0;
    reduced_swing_select <= 1'b0;
    serial_select_n <= 1'b0;
    settle;
    serial_select_n <= 1'b1;
    settle;
    apb(0, 12'h004, 0);
    chk(rd, 32'h80);
    apb(0, 12'h024, 0);
    chk(rd, 32'h1);
    apb(0, 12'h0fc, 0);
    chk(co, 1);
    chk(rd, 32'h0);
    apb(1, 12'h058, 32'h4);
    waitr(2);
    chk(data_capture_clock_out, 0);
    apb(1, 12'h058, 0);
    waitr(2);
    chk(data_capture_clock_out, 1);
    for (int f = 0; f < 3; f++)
    begin
      apb(1, 12'h050, f);
      dchk(16'h9abc, 0, 0, f == 0 ? 16'h9abc : f == 1 ? 16'h1abc :
        16'h9abc ^ (16'h9abc >> 1), 0);
    end
    apb(1, 12'h050, 32'h10);
    settle;
    chk({data_oe, dco_oe}, 2'h0);
    apb(1, 12'h050, 0);
    apb(1, 12'h024, 0);
    settle;
    chk(duty_cycle_stabilizer, 0);
    apb(1, 12'h058, 32'h3);
    settle;
    chk({lvds_mode, reduced_swing}, 2'h3);
    apb(1, 12'h058, 0);
    apb(1, 12'h020, 32'h2);
    settle;
    chk({clock_run, reference_on, data_oe}, 3'h2);
    apb(1, 12'h020, 32'h1);
    settle;
    chk({clock_run, reference_on, data_oe}, 3'h0);
    apb(1, 12'h020, 32'h4);
    power_down_pin <= 1'b1;
    settle;
    chk({clock_run, reference_on}, 2'h1);
    power_down_pin <= 1'b0;
    settle;
    chk({clock_run, reference_on}, 2'h3);
    test_done;
  end
endmodule
